// ---- pmc_regs.svh ----
/*
 Constants for the power-mode controller: register addresses, bit positions, reset values.
 Assumes inclusion by pmc_pkg.sv and the design modules only.
*/
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// =====================================================================
// Register addresses (special-function space)
`define PMC_ADDR_FLASH_SCALE   8'hB6
`define PMC_ADDR_POWER_CTRL    8'h87
`define PMC_ADDR_WAKE_CONFIG   8'hB5

// =====================================================================
// Field positions
`define PMC_POWER_CONTROL_REG_IDLE_BIT      0
`define PMC_POWER_CONTROL_REG_STOP_BIT      1
`define PMC_WCFG_SUSPEND_BIT   6
`define PMC_WCFG_SLEEP_BIT     7
`define PMC_FSCL_BYPASS_BIT    6
`define PMC_WCFG_TOUCH_BIT     0
`define PMC_WCFG_RTC_BIT       1
`define PMC_WCFG_PORT_BIT      2
`define PMC_WCFG_CMP0_BIT      3

// =====================================================================
// Reset values and masks
`define PMC_FSCL_RESET         8'h00
`define PMC_POWER_CONTROL_REG_RESET         8'h00
`define PMC_WCFG_RESET         8'h00
`define PMC_WCFG_SRC_MASK      8'h3F
`define PMC_ZERO8              8'h00
`define PMC_RESET_VECTOR       16'h0000

`endif

// ---- pmc_pkg.sv ----
/*
 Types shared by the power-mode controller files.
 Assumes pmc_regs.svh is on the include path.
*/
`include "pmc_regs.svh"

package pmc_pkg;

  // =====================================================================
  // Power modes
  typedef enum logic [2:0] {
    PMC_NORMAL,
    PMC_IDLE,
    PMC_STOP,
    PMC_SUSPEND,
    PMC_SLEEP
  } pmc_mode_t;

endpackage : pmc_pkg

// ---- pmc_flash_timing.sv ----
/*
 Flash read-timing scale register: only the one-shot bypass bit is stored.
 Assumes an SFR write strobe synchronous to REF_CLK.
*/
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_flash_timing (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            one_shot_en
);

  logic bypass_reg;
  logic bypass_next;

  always_comb begin
    bypass_next = bypass_reg;
    // Takes effect on the write edge, no filler instruction needed
    if (wr_en) begin
      bypass_next = wr_data[`PMC_FSCL_BYPASS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bypass_reg <= 1'(`PMC_FSCL_RESET >> `PMC_FSCL_BYPASS_BIT);
    end else begin
      bypass_reg <= bypass_next;
    end
  end

  // Reserved bits read zero
  always_comb begin
    rd_data                       = `PMC_ZERO8;
    rd_data[`PMC_FSCL_BYPASS_BIT] = bypass_reg;
  end

  // Zero selects the one-shot, one selects the system clock
  assign one_shot_en = ~bypass_reg;

endmodule : pmc_flash_timing

// ---- pmc_power_ctrl.sv ----
/*
 Power-mode controller: power control, wake configuration and flash scale registers,
 mode state machine, processor halt/resume and clock/supply gating outputs.
 Assumes the core issues SFR reads/writes synchronous to REF_CLK, writes land at the end
 of the writing instruction, and the interrupt/reset logic feeds wake and reset requests.
*/
// Functional notes
// - five modes: normal, idle, stop, suspend, sleep
// - idle select halts core after instruction
// - idle keeps registers and memory unchanged
// - peripherals keep running in idle
// - idle ends on enabled interrupt or reset
// - interrupt wake clears idle bit, core resumes
// - interrupt serviced, then next instruction resumes
// - reset wake runs reset sequence from zero
// - enabled watchdog reset ends idle
// - stop disables precision oscillator, reset wakes
// - suspend gates clock, listed sources wake
// - sleep gates core supply, listed sources wake
// - bypass bit picks one-shot or clock timing
// - bypass clear needs no filler instruction
// - stop select enters stop after instruction
// - suspend select gates clock, oscillators off
// - sleep select drops regulator, RAM on supply
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_power_ctrl (
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic              SFR_WR,
  input  wire logic              SFR_RD,
  input  wire logic [7:0]        SFR_ADDR,
  input  wire logic [7:0]        SFR_WDATA,
  output logic      [7:0]        SFR_RDATA,
  input  wire logic              INSTR_DONE,
  input  wire logic              ENABLED_IRQ,
  input  wire logic              ANY_RESET,
  input  wire logic              WATCHDOG_RESET,
  input  wire logic              WAKE_TOUCH,
  input  wire logic              WAKE_RTC,
  input  wire logic              WAKE_PORT_MATCH,
  input  wire logic              WAKE_CMP0,
  input  wire logic              WAKE_RST_PIN,
  output pmc_pkg::pmc_mode_t     MODE,
  output logic                   CORE_HALT,
  output logic                   CORE_RESET_SEQ,
  output logic      [15:0]       RESET_VECTOR,
  output logic                   PRECISION_OSC_EN,
  output logic                   INTERNAL_OSC_EN,
  output logic                   SYSCLK_EN,
  output logic                   CORE_SUPPLY_EN,
  output logic                   RAM_ON_MAIN_SUPPLY,
  output logic                   PERIPH_CLK_EN,
  output logic                   FLASH_ONE_SHOT_EN
);
  import pmc_pkg::*;

  // =====================================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  logic wr_power_control_reg;
  logic wr_wcfg;
  logic wr_fscl;
  logic [7:0] fscl_rdata;

  assign wr_power_control_reg = SFR_WR && hit(SFR_ADDR, `PMC_ADDR_POWER_CTRL);
  assign wr_wcfg = SFR_WR && hit(SFR_ADDR, `PMC_ADDR_WAKE_CONFIG);
  assign wr_fscl = SFR_WR && hit(SFR_ADDR, `PMC_ADDR_FLASH_SCALE);

  // =====================================================================
  // Flash read timing
  pmc_flash_timing u_flash_timing (
    .clk         (REF_CLK),
    .rst         (RST),
    .wr_en       (wr_fscl),
    .wr_data     (SFR_WDATA),
    .rd_data     (fscl_rdata),
    .one_shot_en (FLASH_ONE_SHOT_EN)
  );

  // =====================================================================
  // Mode state and select bits
  pmc_mode_t  mode_reg;
  pmc_mode_t  mode_next;
  logic [7:0] power_control_reg_reg;
  logic [7:0] power_control_reg_next;
  logic [7:0] wcfg_reg;
  logic [7:0] wcfg_next;
  logic       pend_idle_reg;
  logic       pend_idle_next;
  logic       pend_stop_reg;
  logic       pend_stop_next;
  logic       reset_seq_reg;
  logic       reset_seq_next;
  logic       any_reset;
  logic       wake_suspend;
  logic       wake_sleep;

  // Watchdog reset is one more reset source
  assign any_reset = ANY_RESET | WATCHDOG_RESET;

  // Sources other than the reset pin are gated by their enables in the wake configuration
  assign wake_suspend = (WAKE_TOUCH      & wcfg_reg[`PMC_WCFG_TOUCH_BIT]) |
                        (WAKE_RTC        & wcfg_reg[`PMC_WCFG_RTC_BIT]) |
                        (WAKE_PORT_MATCH & wcfg_reg[`PMC_WCFG_PORT_BIT]) |
                        (WAKE_CMP0       & wcfg_reg[`PMC_WCFG_CMP0_BIT]) |
                        WAKE_RST_PIN;
  assign wake_sleep   = (WAKE_RTC        & wcfg_reg[`PMC_WCFG_RTC_BIT]) |
                        (WAKE_PORT_MATCH & wcfg_reg[`PMC_WCFG_PORT_BIT]) |
                        (WAKE_CMP0       & wcfg_reg[`PMC_WCFG_CMP0_BIT]) |
                        WAKE_RST_PIN;

  always_comb begin
    mode_next      = mode_reg;
    power_control_reg_next      = power_control_reg_reg;
    wcfg_next      = wcfg_reg;
    pend_idle_next = pend_idle_reg;
    pend_stop_next = pend_stop_reg;
    reset_seq_next = 1'b0;
    if (wr_power_control_reg) begin
      power_control_reg_next      = SFR_WDATA;
      pend_idle_next = SFR_WDATA[`PMC_POWER_CONTROL_REG_IDLE_BIT];
      pend_stop_next = SFR_WDATA[`PMC_POWER_CONTROL_REG_STOP_BIT];
    end
    if (wr_wcfg) begin
      wcfg_next = SFR_WDATA;
    end
    unique case (mode_reg)
      PMC_NORMAL: begin
        // Idle/stop entry waits for the setting instruction to retire; suspend/sleep enter on the write
        if (INSTR_DONE && pend_stop_reg) begin
          mode_next      = PMC_STOP;
          pend_stop_next = 1'b0;
          pend_idle_next = 1'b0;
        end else if (INSTR_DONE && pend_idle_reg) begin
          mode_next      = PMC_IDLE;
          pend_idle_next = 1'b0;
        end else if (wr_wcfg && SFR_WDATA[`PMC_WCFG_SLEEP_BIT]) begin
          mode_next = PMC_SLEEP;
        end else if (wr_wcfg && SFR_WDATA[`PMC_WCFG_SUSPEND_BIT]) begin
          mode_next = PMC_SUSPEND;
        end
      end
      PMC_IDLE: begin
        // Only an enabled interrupt or a reset ends idle
        if (any_reset) begin
          mode_next = PMC_NORMAL;
        end else if (ENABLED_IRQ) begin
          mode_next = PMC_NORMAL;
          power_control_reg_next[`PMC_POWER_CONTROL_REG_IDLE_BIT] = 1'b0;
        end
      end
      PMC_STOP: begin
        if (any_reset) begin
          mode_next = PMC_NORMAL;
        end
      end
      PMC_SUSPEND: begin
        if (any_reset || wake_suspend) begin
          mode_next = PMC_NORMAL;
          wcfg_next = wcfg_reg & `PMC_WCFG_SRC_MASK;
        end
      end
      PMC_SLEEP: begin
        if (any_reset || wake_sleep) begin
          mode_next = PMC_NORMAL;
          wcfg_next = wcfg_reg & `PMC_WCFG_SRC_MASK;
        end
      end
      default: begin
        mode_next = PMC_NORMAL;
      end
    endcase
    // Reset from any mode restarts at the reset vector
    if (any_reset) begin
      mode_next      = PMC_NORMAL;
      power_control_reg_next      = `PMC_POWER_CONTROL_REG_RESET;
      wcfg_next      = `PMC_WCFG_RESET;
      pend_idle_next = 1'b0;
      pend_stop_next = 1'b0;
      reset_seq_next = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      mode_reg      <= PMC_NORMAL;
      power_control_reg_reg      <= `PMC_POWER_CONTROL_REG_RESET;
      wcfg_reg      <= `PMC_WCFG_RESET;
      pend_idle_reg <= 1'b0;
      pend_stop_reg <= 1'b0;
      reset_seq_reg <= 1'b0;
    end else begin
      mode_reg      <= mode_next;
      power_control_reg_reg      <= power_control_reg_next;
      wcfg_reg      <= wcfg_next;
      pend_idle_reg <= pend_idle_next;
      pend_stop_reg <= pend_stop_next;
      reset_seq_reg <= reset_seq_next;
    end
  end

  // =====================================================================
  // Outputs; one encoded mode register keeps modes exclusive
  assign MODE           = mode_reg;
  // Halt freezes the core only; state and memory are untouched
  assign CORE_HALT      = (mode_reg != PMC_NORMAL);
  assign CORE_RESET_SEQ = reset_seq_reg;
  assign RESET_VECTOR   = `PMC_RESET_VECTOR;
  // Peripheral clock survives idle
  assign PERIPH_CLK_EN  = (mode_reg == PMC_NORMAL) || (mode_reg == PMC_IDLE);
  assign PRECISION_OSC_EN   = (mode_reg == PMC_NORMAL) || (mode_reg == PMC_IDLE);
  assign INTERNAL_OSC_EN    = (mode_reg != PMC_SUSPEND) && (mode_reg != PMC_SLEEP);
  assign SYSCLK_EN          = (mode_reg != PMC_SUSPEND) && (mode_reg != PMC_SLEEP);
  assign CORE_SUPPLY_EN     = (mode_reg != PMC_SLEEP);
  assign RAM_ON_MAIN_SUPPLY = (mode_reg == PMC_SLEEP);

  // =====================================================================
  // Read data, registered
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = `PMC_ZERO8;
    if (SFR_RD) begin
      if (hit(SFR_ADDR, `PMC_ADDR_FLASH_SCALE)) begin
        rdata_next = fscl_rdata;
      end else if (hit(SFR_ADDR, `PMC_ADDR_POWER_CTRL)) begin
        rdata_next = power_control_reg_reg;
      end else if (hit(SFR_ADDR, `PMC_ADDR_WAKE_CONFIG)) begin
        rdata_next = wcfg_reg;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_reg <= `PMC_ZERO8;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign SFR_RDATA = rdata_reg;

endmodule : pmc_power_ctrl

// ---- pmc_power_ctrl_monitor.sv ----
/*
 Checker for pmc_power_ctrl: mode entry, wake refusal and gating outputs.
 Assumes it is bound onto pmc_power_ctrl and sees its ports only.
*/
`timescale 1ns/1ps
module pmc_power_ctrl_monitor (
  input logic               REF_CLK,
  input logic               RST,
  input logic               SFR_WR,
  input logic         [7:0] SFR_ADDR,
  input logic         [7:0] SFR_WDATA,
  input logic               INSTR_DONE,
  input logic               ENABLED_IRQ,
  input logic               ANY_RESET,
  input logic               WATCHDOG_RESET,
  input pmc_pkg::pmc_mode_t MODE,
  input logic               CORE_HALT,
  input logic               CORE_RESET_SEQ,
  input logic               PRECISION_OSC_EN,
  input logic               INTERNAL_OSC_EN,
  input logic               PERIPH_CLK_EN,
  input logic        [15:0] RESET_VECTOR,
  input logic               SYSCLK_EN,
  input logic               CORE_SUPPLY_EN,
  input logic               RAM_ON_MAIN_SUPPLY,
  input logic               FLASH_ONE_SHOT_EN
);
  import pmc_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // =====================================================================
  // Mode entry and wake
  chk_halt_decode: assert property (CORE_HALT == (MODE != PMC_NORMAL))
    else $error("halt flag disagrees with mode");
  chk_idle_entry: assert property (SFR_WR && SFR_ADDR == 8'h87 && SFR_WDATA == 8'h01
    ##1 INSTR_DONE && !ANY_RESET && !WATCHDOG_RESET |=> MODE == PMC_IDLE)
    else $error("idle not entered after retire");
  chk_idle_irq_exit: assert property (MODE == PMC_IDLE && ENABLED_IRQ |=> MODE == PMC_NORMAL)
    else $error("interrupt did not end idle");
  chk_idle_stays: assert property (MODE == PMC_IDLE && !ENABLED_IRQ && !ANY_RESET
    && !WATCHDOG_RESET |=> MODE == PMC_IDLE)
    else $error("idle left without cause");
  chk_reset_wake: assert property (ANY_RESET || WATCHDOG_RESET
    |=> MODE == PMC_NORMAL && CORE_RESET_SEQ)
    else $error("reset did not restart core");
  chk_stop_holds: assert property (MODE == PMC_STOP && !ANY_RESET && !WATCHDOG_RESET
    |=> MODE == PMC_STOP && !PRECISION_OSC_EN)
    else $error("stop left without reset");
  chk_suspend_gated: assert property (MODE == PMC_SUSPEND |-> !SYSCLK_EN)
    else $error("clock running in suspend");
  chk_sleep_supply: assert property (MODE == PMC_SLEEP
    |-> !CORE_SUPPLY_EN && RAM_ON_MAIN_SUPPLY)
    else $error("supply not switched in sleep");
  chk_oneshot_write: assert property (SFR_WR && SFR_ADDR == 8'hB6
    |=> FLASH_ONE_SHOT_EN ^ $past(SFR_WDATA[6]))
    else $error("one-shot enable not following bypass");
  chk_awake_enables: assert property (MODE == PMC_NORMAL || MODE == PMC_IDLE
    |-> PERIPH_CLK_EN && INTERNAL_OSC_EN && CORE_SUPPLY_EN && SYSCLK_EN)
    else $error("clock or supply off while awake");
  chk_osc_gated: assert property (MODE == PMC_SUSPEND || MODE == PMC_SLEEP
    |-> !INTERNAL_OSC_EN && !PRECISION_OSC_EN)
    else $error("oscillator running in deep mode");
  chk_vector_zero: assert property (CORE_RESET_SEQ |-> RESET_VECTOR == 16'h0000)
    else $error("reset vector not zero");
  cp_idle_out: cover property (MODE == PMC_IDLE ##1 MODE == PMC_NORMAL);
  cp_suspend_out: cover property (MODE == PMC_SUSPEND ##1 MODE == PMC_NORMAL);
  cp_stop_out: cover property (MODE == PMC_STOP ##1 MODE == PMC_NORMAL);
  cp_sleep_out: cover property (MODE == PMC_SLEEP ##1 MODE == PMC_NORMAL);
endmodule : pmc_power_ctrl_monitor

bind pmc_power_ctrl pmc_power_ctrl_monitor u_mon (.*);

// ---- pmc_core_model.sv ----
/*
 Processor-core model: retires a register-writing instruction; a later write before retirement restarts the count.
 Assumes slow picks prompt or late retirement.
*/
`timescale 1ns/1ps
module pmc_core_model (
  input  logic clk,
  input  logic rst,
  input  logic sfr_wr,
  input  logic slow,
  output logic instr_done
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  // =====================================================================
  // Retire never in the write cycle, so mode bits land first
  always_comb begin
    cnt_next = cnt_reg;
    if (sfr_wr) begin
      cnt_next = slow ? 2'h3 : 2'h1;
    end else if (cnt_reg != 2'h0) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end
  always_ff @(posedge clk) begin
    cnt_reg <= rst ? 2'h0 : cnt_next;
  end
  assign instr_done = (cnt_reg == 2'h1);
endmodule : pmc_core_model

// ---- power_mode_controller_tb_top.sv ----
/*
 Self-checking bench for pmc_power_ctrl: registers, every mode, wake sources.
 Assumes pmc_core_model stands in for the processor core.
*/
`timescale 1ns/1ps
module power_mode_controller_tb_top;
  import pmc_pkg::*;
  logic REF_CLK = 1'b0, RST = 1'b1, SFR_WR = 1'b0, SFR_RD = 1'b0, slow = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, ev = 8'h00, SFR_RDATA, v;
  logic WAKE_TOUCH, WAKE_RTC, WAKE_PORT_MATCH, WAKE_CMP0, WAKE_RST_PIN, INSTR_DONE;
  logic ENABLED_IRQ, ANY_RESET, WATCHDOG_RESET, CORE_HALT, CORE_RESET_SEQ;
  logic PRECISION_OSC_EN, INTERNAL_OSC_EN, SYSCLK_EN, CORE_SUPPLY_EN;
  logic RAM_ON_MAIN_SUPPLY, PERIPH_CLK_EN, FLASH_ONE_SHOT_EN, pk = 1'b0, rd_d = 1'b0;
  logic [15:0] RESET_VECTOR;
  pmc_mode_t   MODE;
  logic [8:0]  q[$];
  logic [8:0]  e;
  logic [8:0]  g;
  logic [39:0] tbl[8];
  integer      failures = 0, checks_done = 0, seed = 32'he332, i, k;
  assign {WATCHDOG_RESET, ANY_RESET, ENABLED_IRQ, WAKE_RST_PIN, WAKE_CMP0, WAKE_PORT_MATCH,
          WAKE_RTC, WAKE_TOUCH} = ev;
  always #50 REF_CLK = ~REF_CLK;
  pmc_power_ctrl dut (.*);
  pmc_core_model u_core (.clk(REF_CLK), .rst(RST), .sfr_wr(SFR_WR), .slow(slow),
                         .instr_done(INSTR_DONE));
  // =====================================================================
  // Read and peek drivers note each expected result; writes note none
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    SFR_WR <= 1'b1;
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    @(posedge REF_CLK);
    SFR_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge REF_CLK);
    SFR_RD <= 1'b1;
    SFR_ADDR <= a;
    q.push_back({1'b1, x});
    @(posedge REF_CLK);
    SFR_RD <= 1'b0;
  endtask : rd
  task automatic peek(input logic [7:0] m);
    @(posedge REF_CLK);
    pk <= 1'b1;
    q.push_back({1'b0, m});
    @(posedge REF_CLK);
    pk <= 1'b0;
  endtask : peek
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // =====================================================================
  // Watcher: read data one cycle after the strobe, mode on a peek
  always @(posedge REF_CLK) begin
    if (rd_d || pk) begin
      e = (q.size() != 0) ? q.pop_front() : 9'hxxx;
      g = rd_d ? {1'b1, SFR_RDATA} : {1'b0, 5'h00, MODE};
      checks_done++;
      if (e !== g) begin
        failures++;
        $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
    end
    rd_d <= SFR_RD;
  end
  initial begin
    repeat (3000) @(posedge REF_CLK);
    failures++;
    report_and_stop();
  end
  // =====================================================================
  // Main sequence; rows: address, data, mode, events that must not wake, waking event
  initial begin
    tbl[0] = {16'h8701, 5'h00, PMC_IDLE, 16'h0F20};
    tbl[1] = {16'h8701, 5'h00, PMC_IDLE, 16'h0F80};
    tbl[2] = {16'h8701, 5'h00, PMC_IDLE, 16'h0040};
    tbl[3] = {16'h8703, 5'h00, PMC_STOP, 16'h2F40};
    tbl[4] = {16'hB541, 5'h00, PMC_SUSPEND, 16'h2E01};
    tbl[5] = {16'hB548, 5'h00, PMC_SUSPEND, 16'h2710};
    tbl[6] = {16'hB5C2, 5'h00, PMC_SLEEP, 16'h2D02};
    tbl[7] = {16'hB58F, 5'h00, PMC_SLEEP, 16'h2104};
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(8'hB6, 8'h00);
    rd(8'h10, 8'h00);
    for (i = 0; i < 6; i++) begin
      v = 8'($random(seed)) & 8'h7F; // Reserved top bit always written zero
      wr(8'hB6, v);
      rd(8'hB6, {1'b0, v[6], 6'h00});
    end
    for (i = 0; i < 8; i++) begin
      slow <= i[0];
      wr(8'hB6, 8'h40);
      wr(8'hB6, 8'h00);
      wr(tbl[i][39:32], tbl[i][31:24]);
      for (k = 0; k < 8 && MODE == PMC_NORMAL; k++) @(posedge REF_CLK);
      peek(tbl[i][23:16]);
      ev <= tbl[i][15:8];
      repeat (3) @(posedge REF_CLK);
      ev <= 8'h00;
      peek(tbl[i][23:16]);
      ev <= tbl[i][7:0];
      @(posedge REF_CLK);
      ev <= 8'h00;
      peek(8'h00);
      rd(8'h87, 8'h00);
      rd(8'hB6, 8'h00);
      rd(8'hB5, (tbl[i][39:32] == 8'hB5) ? (tbl[i][31:24] & 8'h3F) : 8'h00);
    end
    repeat (4) @(posedge REF_CLK);
    if (q.size() != 0) begin
      failures++;
    end
    report_and_stop();
  end
endmodule : power_mode_controller_tb_top
